// ---- core/otf_regs.sv ----
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "otf_map.svh"

module otf_regs #(
    parameter int STEP_CYCLES = `OTF_STEP_CYCLES
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    input  wire otf_pkg::otf_avm_req_t i_avm,
    output otf_pkg::otf_avm_rsp_t      o_avm,
    input  wire logic                  i_overload_n,
    output otf_pkg::otf_cfg_t          o_cfg,
    output logic                       o_alert_n,
    output logic                       o_irq
);
    import otf_pkg::*;

    typedef struct packed {
        otf_bus_state_t bus;
        logic [31:0]    rdata;
        logic [7:0]     dur_status;
        logic [7:0]     dur_limit;
        logic [7:0]     tach_ppr;
        logic [7:0]     pin_cfg;
        logic [7:0]     cfg3;
        logic [7:0]     int_status2;
        logic [7:0]     int_mask2;
        logic [7:0]     steps;
        logic           active;
        logic           alert_n;
        logic           irq;
        logic           waitreq;
        otf_cfg_t       cfg;
    } otf_state_t;

    otf_state_t state_reg;
    otf_state_t state_next;
    logic       step_tick;
    logic       monitor_on;
    logic       asserted;

    // ==========================================================
    // Duration step timer
    // timing needs enable
    assign monitor_on = state_reg.cfg3[`OTF_BIT_OVERLOAD_EN] &
                        state_reg.pin_cfg[`OTF_BIT_OVERLOAD_SEL];
    assign asserted   = monitor_on & ~i_overload_n;

    otf_step_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_step (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_run     (asserted),
        .o_tick    (step_tick)
    );

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] idx;
        logic       do_wr;
        logic       do_rd;
        logic       rd_clear;
        logic       ev_limit;
        logic       ev_assert;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic [7:0] steps_n;
        idx        = i_avm.address[9:2];
        wbyte      = i_avm.writedata[7:0];
        do_wr      = (state_reg.bus == OTF_BUS_IDLE) & i_avm.write &
                     i_avm.byteenable[0];
        do_rd      = (state_reg.bus == OTF_BUS_IDLE) & i_avm.read;
        rd_clear   = do_rd & (idx == `OTF_IDX_DURATION_STATUS);
        state_next = state_reg;
        rbyte      = 8'h00;
        ev_limit   = 1'b0;
        state_next.active = asserted;
        ev_assert  = asserted & ~state_reg.active;
        steps_n    = state_reg.steps;

        // Duration count in steps since assertion
        if (ev_assert) begin
            steps_n = 8'h00;
        end else if (asserted && step_tick && state_reg.steps != 8'hff) begin
            steps_n = state_reg.steps + 8'h01;
        end
        state_next.steps = steps_n;

        // Status register, cleared on read
        if (rd_clear) begin
            state_next.dur_status = 8'h00;
        end
        if (ev_assert) begin
            state_next.dur_status[0] = 1'b1;
        end
        if (asserted && steps_n >= 8'h02) begin
            state_next.dur_status = steps_n;
        end

        ev_limit = asserted & ((state_reg.dur_limit == 8'h00) ? ev_assert :
                   (step_tick && steps_n > state_reg.dur_limit &&
                    state_reg.steps <= state_reg.dur_limit));

        // Register writes; test registers and duration status ignore writes
        if (do_wr) begin
            unique case (idx)
                `OTF_IDX_DURATION_LIMIT: state_next.dur_limit = wbyte;
                `OTF_IDX_TACH_PPR:       state_next.tach_ppr  = wbyte;
                `OTF_IDX_PIN_CONFIG:     state_next.pin_cfg   = {4'h0, wbyte[3:0]};
                `OTF_IDX_MON_CONFIG3:    state_next.cfg3      = wbyte;
                `OTF_IDX_INT_MASK2:      state_next.int_mask2 = wbyte;
                `OTF_IDX_INT_STATUS2:
                    state_next.int_status2 = state_reg.int_status2 & ~wbyte;
                default: ;
            endcase
        end
        // Set wins over write-one-to-clear
        if (ev_limit) begin
            state_next.int_status2[`OTF_BIT_TIMER_EVENT] = 1'b1;
        end

        // Read mux
        unique case (idx)
            `OTF_IDX_DURATION_STATUS: rbyte = state_reg.dur_status;
            `OTF_IDX_DURATION_LIMIT:  rbyte = state_reg.dur_limit;
            `OTF_IDX_TACH_PPR:        rbyte = state_reg.tach_ppr;
            `OTF_IDX_PIN_CONFIG:      rbyte = state_reg.pin_cfg;
            `OTF_IDX_MON_CONFIG3:     rbyte = state_reg.cfg3;
            `OTF_IDX_INT_MASK2:       rbyte = state_reg.int_mask2;
            `OTF_IDX_INT_STATUS2:     rbyte = state_reg.int_status2;
            `OTF_IDX_TEST_A:          rbyte = `OTF_RST_TEST;
            `OTF_IDX_TEST_B:          rbyte = `OTF_RST_TEST;
            default:                  rbyte = 8'h00;
        endcase

        // Bus handshake: one wait cycle, answer in second cycle
        unique case (state_reg.bus)
            OTF_BUS_IDLE: begin
                if (i_avm.read || i_avm.write) begin
                    state_next.bus   = OTF_BUS_ACK;
                    state_next.rdata = {24'h0, rbyte};
                end
            end
            OTF_BUS_ACK: begin
                state_next.bus = OTF_BUS_IDLE;
            end
        endcase
        // Waitrequest drops for the answer cycle only
        state_next.waitreq = ~(state_next.bus == OTF_BUS_ACK);

        // Outputs of configuration
        // field decode
        state_next.cfg.tach_ch1_pulse_sel   = state_next.tach_ppr[1:0];
        state_next.cfg.tach_ch2_pulse_sel   = state_next.tach_ppr[3:2];
        state_next.cfg.tach_ch3_pulse_sel   = state_next.tach_ppr[5:4];
        state_next.cfg.tach_ch4_pulse_sel   = state_next.tach_ppr[7:6];
        state_next.cfg.tach_input_threshold =
            state_next.pin_cfg[`OTF_LSB_THRESHOLD +: 2];
        state_next.cfg.alert_pin_select    = state_next.pin_cfg[`OTF_BIT_ALERT_SEL];
        state_next.cfg.overload_pin_select = state_next.pin_cfg[`OTF_BIT_OVERLOAD_SEL];
        state_next.cfg.overload_enable     = state_next.cfg3[`OTF_BIT_OVERLOAD_EN];

        state_next.irq = |(state_next.int_status2 & ~state_next.int_mask2);
        state_next.alert_n = ~(state_next.irq &
                               state_next.pin_cfg[`OTF_BIT_ALERT_SEL]);
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_reg             <= '0;
            state_reg.bus         <= OTF_BUS_IDLE;
            state_reg.dur_status  <= `OTF_RST_DURATION_STATUS;
            state_reg.dur_limit   <= `OTF_RST_DURATION_LIMIT;
            state_reg.tach_ppr    <= `OTF_RST_TACH_PPR;
            state_reg.pin_cfg     <= `OTF_RST_PIN_CONFIG;
            state_reg.cfg3        <= `OTF_RST_MON_CONFIG3;
            state_reg.int_mask2   <= `OTF_RST_INT_MASK2;
            state_reg.alert_n     <= 1'b1;
            state_reg.waitreq     <= 1'b1;
            state_reg.cfg         <= '{default: 2'b01, tach_input_threshold: 2'b00,
                                       alert_pin_select: 1'b0,
                                       overload_pin_select: 1'b0,
                                       overload_enable: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    assign o_avm             = '{readdata: state_reg.rdata, waitrequest: state_reg.waitreq};
    assign o_cfg             = state_reg.cfg;
    assign o_alert_n         = state_reg.alert_n;
    assign o_irq             = state_reg.irq;
endmodule

// ---- core/otf_map.svh ----
`ifndef OTF_MAP_SVH
`define OTF_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define OTF_IDX_INT_STATUS2      8'h42
`define OTF_IDX_INT_MASK2        8'h75
`define OTF_IDX_MON_CONFIG3      8'h78
`define OTF_IDX_DURATION_STATUS  8'h79
`define OTF_IDX_DURATION_LIMIT   8'h7a
`define OTF_IDX_TACH_PPR         8'h7b
`define OTF_IDX_PIN_CONFIG       8'h7d
`define OTF_IDX_TEST_A           8'h7e
`define OTF_IDX_TEST_B           8'h7f

// ==========================================================
// Reset values
`define OTF_RST_DURATION_STATUS  8'h00
`define OTF_RST_DURATION_LIMIT   8'h00
`define OTF_RST_TACH_PPR         8'h55
`define OTF_RST_PIN_CONFIG       8'h00
`define OTF_RST_MON_CONFIG3      8'h00
`define OTF_RST_INT_MASK2        8'h00
`define OTF_RST_TEST             8'h00

// ==========================================================
// Field positions
`define OTF_BIT_TIMER_EVENT      5
`define OTF_BIT_OVERLOAD_EN      1
`define OTF_BIT_ALERT_SEL        0
`define OTF_BIT_OVERLOAD_SEL     1
`define OTF_LSB_THRESHOLD        2

// ==========================================================
// Timing
`define OTF_CLK_NS               20
`define OTF_STEP_NS              22760000
`define OTF_STEP_CYCLES          (`OTF_STEP_NS / `OTF_CLK_NS)

`endif

// ---- core/otf_pkg.sv ----
package otf_pkg;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [9:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } otf_avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } otf_avm_rsp_t;

    typedef struct packed {
        logic [1:0] tach_ch1_pulse_sel;
        logic [1:0] tach_ch2_pulse_sel;
        logic [1:0] tach_ch3_pulse_sel;
        logic [1:0] tach_ch4_pulse_sel;
        logic [1:0] tach_input_threshold;
        logic       alert_pin_select;
        logic       overload_pin_select;
        logic       overload_enable;
    } otf_cfg_t;

    typedef enum logic [1:0] {
        OTF_BUS_IDLE,
        OTF_BUS_ACK
    } otf_bus_state_t;

endpackage

// ---- core/otf_step_timer.sv ----
`timescale 1ns/1ns
`include "otf_map.svh"

module otf_step_timer #(
    parameter int STEP_CYCLES = `OTF_STEP_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_run,
    output logic      o_tick
);
    import otf_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } otf_prescale_state_t;

    otf_prescale_state_t state_reg;
    otf_prescale_state_t state_next;

    // ==========================================================
    // Step prescaler, restarts whenever the run level drops
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (!i_run) begin
            state_next.cnt = 32'h0;
        end else if (state_reg.cnt == 32'(STEP_CYCLES - 1)) begin
            state_next.cnt  = 32'h0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_tick = state_reg.tick;
endmodule

// ---- tb/otf_regs_monitor.sv ----
`timescale 1ns/1ns
`include "otf_map.svh"
module otf_regs_monitor #(
    parameter int STEP_CYCLES = 4
) (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst_n,
    input wire otf_pkg::otf_avm_req_t i_avm,
    input wire otf_pkg::otf_avm_rsp_t o_avm,
    input wire logic                  i_overload_n,
    input wire otf_pkg::otf_cfg_t     o_cfg,
    input wire logic                  o_alert_n,
    input wire logic                  o_irq
);
    import otf_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ====
    // Bus handshake
    a_wait_one_cycle: assert property (!o_avm.waitrequest |=> o_avm.waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_request_answered: assert property ($rose(i_avm.read || i_avm.write) |=> !o_avm.waitrequest)
        else $error("request not answered in one cycle");
    a_read_upper_zero: assert property (!o_avm.waitrequest |-> o_avm.readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // ====
    // Register effects
    a_pin_cfg_write: assert property (
        !o_avm.waitrequest && i_avm.write && i_avm.byteenable[0]
        && i_avm.address[9:2] == `OTF_IDX_PIN_CONFIG |-> {o_cfg.tach_input_threshold,
        o_cfg.overload_pin_select, o_cfg.alert_pin_select} == i_avm.writedata[3:0])
        else $error("pin config outputs do not follow write");
    a_pulse_sel_write: assert property (
        !o_avm.waitrequest && i_avm.write && i_avm.byteenable[0]
        && i_avm.address[9:2] == `OTF_IDX_TACH_PPR |-> {o_cfg.tach_ch4_pulse_sel,
        o_cfg.tach_ch3_pulse_sel, o_cfg.tach_ch2_pulse_sel, o_cfg.tach_ch1_pulse_sel}
        == i_avm.writedata[7:0])
        else $error("pulse selections do not follow write");
    a_alert_needs_irq: assert property (!o_alert_n |-> o_irq)
        else $error("alert low without unmasked event");
    a_alert_pin_off: assert property (
        !o_cfg.alert_pin_select && !$past(o_cfg.alert_pin_select) |-> o_alert_n)
        else $error("alert driven while pin not selected");
    a_irq_clear_cause: assert property ($fell(o_irq) |-> $past(i_avm.write))
        else $error("interrupt dropped without a write");
    a_reset_values: assert property (
        disable iff (1'b0) !i_rst_n |=> o_cfg == 13'h0aa0 && !o_irq && o_alert_n)
        else $error("outputs not at reset values");
endmodule

bind otf_regs otf_regs_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avm(i_avm), .o_avm(o_avm),
    .i_overload_n(i_overload_n), .o_cfg(o_cfg), .o_alert_n(o_alert_n), .o_irq(o_irq));

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`include "otf_map.svh"
module testbench;
    import otf_pkg::*;
    // ====
    // Signals and design
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         ovl_n = 1'b1;
    otf_avm_req_t req = '0;
    otf_avm_rsp_t rsp;
    otf_cfg_t     cfg;
    logic         alert_n;
    logic         irq;
    int           miscompares = 0;
    int           checks = 0;
    int           seed = 71570;
    logic [7:0]   rd;
    logic [7:0]   v;
    logic         f;
    logic [7:0]   ra[7] = '{8'h79, 8'h7a, 8'h7b, 8'h7d, 8'h7e, 8'h7f, 8'h10};
    logic [7:0]   rv[7] = '{8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]   rw[7] = '{8'h00, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00};
    int           ks[7] = '{0, 1, 3, 5, 0, 5, 260};
    int           ls[7] = '{0, 3, 3, 3, 0, 3, 254};
    logic [6:0]   msk = 7'b0100000;
    logic [6:0]   al = 7'b1110111;

    always #10 clk = ~clk;

    otf_regs #(.STEP_CYCLES(4)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avm(req),
        .o_avm(rsp), .i_overload_n(ovl_n), .o_cfg(cfg), .o_alert_n(alert_n), .o_irq(irq));

    // ====
    // Tasks
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        req <= '{read: !wr_en, write: wr_en, address: {idx, 2'b00}, byteenable: 4'h1,
                 writedata: {24'h0, wd}};
        @(posedge clk);
        while (rsp.waitrequest !== 1'b0) @(posedge clk);
        rd = rsp.readdata[7:0];
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check($sformatf("reg %h", idx), rd, exp);
    endtask
    task automatic hold(input int cyc);
        @(posedge clk);
        ovl_n <= 1'b0;
        repeat (cyc) @(posedge clk);
        ovl_n <= 1'b1;
    endtask
    function automatic logic [7:0] exp_stat(input int k);
        return (k < 2) ? 8'h01 : ((k > 255) ? 8'hff : 8'(k));
    endfunction
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    // ====
    // Scenarios
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rdchk(ra[i], rv[i]); // reset values
        for (int i = 0; i < 7; i++) begin
            if (ra[i] != `OTF_IDX_TEST_A && ra[i] != `OTF_IDX_TEST_B) wr(ra[i], 8'hff);
        end
        for (int i = 0; i < 7; i++) rdchk(ra[i], rw[i]); // access kinds
        for (int c = 0; c < 16; c++) begin
            v = 8'($random(seed));
            v = {v[7:2], 2'(c)};
            wr(`OTF_IDX_TACH_PPR, v);
            wr(`OTF_IDX_PIN_CONFIG, {v[7:4], 4'(c)});
            rdchk(`OTF_IDX_PIN_CONFIG, {4'h0, 4'(c)}); // unused bits zero
            check("pulse_sel", {cfg.tach_ch4_pulse_sel, cfg.tach_ch3_pulse_sel,
                cfg.tach_ch2_pulse_sel, cfg.tach_ch1_pulse_sel}, v);
            check("pin_sel", {4'h0, cfg.tach_input_threshold, cfg.overload_pin_select,
                cfg.alert_pin_select}, 8'(c)); // selects
        end
        wr(`OTF_IDX_PIN_CONFIG, 8'h02);
        hold(20);
        rdchk(`OTF_IDX_DURATION_STATUS, 8'h00); // timing off
        wr(`OTF_IDX_MON_CONFIG3, 8'h02);
        rdchk(`OTF_IDX_MON_CONFIG3, 8'h02); // enable readback
        check("ovl_en", {7'h0, cfg.overload_enable}, 8'h01);
        wr(`OTF_IDX_PIN_CONFIG, 8'h00);
        hold(20);
        rdchk(`OTF_IDX_DURATION_STATUS, 8'h00); // pin not overload
        ks[4] = 2 + ($unsigned($random(seed)) % 30);
        ls[4] = 1 + ($unsigned($random(seed)) % 30);
        for (int i = 0; i < 7; i++) begin
            wr(`OTF_IDX_PIN_CONFIG, {6'h0, 1'b1, al[i]});
            wr(`OTF_IDX_INT_MASK2, {2'b0, msk[i], 5'h0});
            rdchk(`OTF_IDX_INT_MASK2, {2'b0, msk[i], 5'h0});
            wr(`OTF_IDX_DURATION_LIMIT, 8'(ls[i]));
            hold(4 * ks[i] + 2);
            f = (ls[i] == 0) || (ks[i] > ls[i]);
            rdchk(`OTF_IDX_DURATION_STATUS, exp_stat(ks[i]));
            check("irq", {7'h0, irq}, {7'h0, f && !msk[i]}); // event
            check("alert_n", {7'h0, alert_n}, {7'h0, !(f && !msk[i] && al[i])});
            rdchk(`OTF_IDX_DURATION_STATUS, 8'h00); // cleared by read
            rdchk(`OTF_IDX_INT_STATUS2, {2'b0, f, 5'h0}); // status bit
            wr(`OTF_IDX_INT_STATUS2, 8'h20);
            wr(`OTF_IDX_INT_MASK2, 8'h00);
            check("irq_clr", {7'h0, irq}, 8'h00); // cleared
        end
        give_verdict();
    end
endmodule
